/* File: logic/sfi_system_irq.sv */
/*
 * System interrupt enable and flag registers with maskable and
 * nonmaskable gating, event status interrupt and Avalon-MM access.
 * Assumes all event inputs are synchronous one-cycle pulses or levels.
 */
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sfi_system_irq
	import sfi_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic power_up_clear_in,
	input wire logic [SFI_ADDR_W-1:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [SFI_DATA_W-1:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [SFI_DATA_W-1:0] readdata_out,
	output logic waitrequest_out,
	input wire logic wdt_overflow_in,
	input wire logic wdt_key_violation_in,
	input wire logic wdt_interval_in,
	input wire logic wdt_interval_mode_in,
	input wire logic osc_fault_in,
	input wire logic nmi_pin_event_in,
	input wire logic rst_pin_reset_in,
	input wire logic flash_violation_in,
	input wire logic gie_in,
	input wire logic [SFI_PORT2_N-1:0] port2_edge_in,
	output logic nmi_request_out,
	output logic wdt_irq_request_out,
	output logic wdt_reset_request_out,
	output logic irq_out
);
	sfi_event_s ev;
	sfi_access_s acc;
	logic take;
	logic wait_q;
	logic wr_stb;
	logic [SFI_REG_W-1:0] en_low;
	logic [SFI_REG_W-1:0] next_en_low;
	logic [SFI_REG_W-1:0] flag_low;
	logic [SFI_REG_W-1:0] flag_set;
	logic [SFI_REG_W-1:0] flag_clr;
	logic [SFI_PORT2_N-1:0] port2_irq_flags;
	logic [SFI_EV_N-1:0] irq_status;
	logic [SFI_EV_N-1:0] irq_enable;
	logic [SFI_EV_N-1:0] next_irq_enable;
	logic [SFI_EV_N-1:0] ev_set;
	logic [SFI_EV_N-1:0] ev_clr;
	logic [SFI_REG_W-1:0] rd_mux;
	logic [SFI_DATA_W-1:0] next_readdata;
	logic next_nmi_request;
	logic next_wdt_irq_request;
	logic next_wdt_reset_request;
	logic next_irq;
	logic watchdog_irq_enable;
	logic osc_fault_irq_enable;
	logic pin_nmi_irq_enable;
	logic flash_violation_irq_enable;

	assign ev.wdt_overflow = wdt_overflow_in;
	assign ev.wdt_key_violation = wdt_key_violation_in;
	assign ev.wdt_interval = wdt_interval_in;
	assign ev.osc_fault = osc_fault_in;
	assign ev.nmi_pin = nmi_pin_event_in;
	assign ev.flash_violation = flash_violation_in;

	sfi_avalon_slave u_bus (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.address_in(address_in),
		.read_in(read_in),
		.write_in(write_in),
		.writedata_in(writedata_in),
		.byteenable_in(byteenable_in),
		.waitrequest_out(wait_q),
		.take_out(take),
		.access_out(acc)
	);

	// Writes land on the edge where waitrequest is seen low
	assign wr_stb = acc.wr && !wait_q;

	assign watchdog_irq_enable = en_low[SFI_BIT_WDT];
	assign osc_fault_irq_enable = en_low[SFI_BIT_OSC];
	assign pin_nmi_irq_enable = en_low[SFI_BIT_NMI];
	assign flash_violation_irq_enable = en_low[SFI_BIT_ACCV];

	// Enable registers: plain reset values; power-up clear reloads the low enable byte only, not the event enable
	always_comb
	begin
		next_en_low = en_low;
		next_irq_enable = irq_enable;
		if (power_up_clear_in)
			next_en_low = SFI_RST_VALUE;
		else if (wr_stb && acc.idx == SFI_IDX_EN_LOW)
			next_en_low = acc.wdata & SFI_EN_LOW_MASK;
		if (wr_stb && acc.idx == SFI_IDX_IRQ_ENABLE)
			next_irq_enable = acc.wdata[SFI_EV_N-1:0] & SFI_EV_MASK;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			en_low <= SFI_RST_VALUE;
			irq_enable <= SFI_EV_RST_VALUE;
		end
		else
		begin
			en_low <= next_en_low;
			irq_enable <= next_irq_enable;
		end
	end

	// Flag byte sources; flash violation flag stays in the flash module
	always_comb
	begin
		flag_set = SFI_RST_VALUE;
		flag_set[SFI_BIT_WDT] = (ev.wdt_overflow && !wdt_interval_mode_in)
			|| ev.wdt_key_violation
			|| (ev.wdt_interval && wdt_interval_mode_in);
		flag_set[SFI_BIT_OSC] = ev.osc_fault;
		flag_set[SFI_BIT_NMI] = ev.nmi_pin;
		flag_clr = SFI_RST_VALUE;
		if (power_up_clear_in)
			flag_clr = SFI_FLAG_PUC_CLR;
		if (rst_pin_reset_in)
			flag_clr = flag_clr | SFI_FLAG_WDT_ONLY;
	end

	// Watchdog flag reaches zero on power-on through the async reset
	sfi_sticky_bits #(
		.W(SFI_REG_W),
		.PRESENT(SFI_FLAG_LOW_MASK),
		.RST_VALUE(SFI_RST_VALUE)
	) u_flag_low (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.set_in(flag_set),
		.clr_in(flag_clr),
		.wr_in(wr_stb && acc.idx == SFI_IDX_FLAG_LOW),
		.wdata_in(acc.wdata),
		.q_out(flag_low)
	);

	// Full eight-bit second-port flag row, all eight pins bonded or not
	sfi_sticky_bits #(
		.W(SFI_PORT2_N),
		.PRESENT(SFI_FULL_MASK),
		.RST_VALUE(SFI_RST_VALUE)
	) u_port2 (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.set_in(port2_edge_in),
		.clr_in(power_up_clear_in ? SFI_FULL_MASK : SFI_RST_VALUE),
		.wr_in(wr_stb && acc.idx == SFI_IDX_PORT2_FLAGS),
		.wdata_in(acc.wdata),
		.q_out(port2_irq_flags)
	);

	// Event status: sticky, cleared by writing ones to the clear index
	always_comb
	begin
		ev_set = SFI_EV_RST_VALUE;
		ev_set[SFI_EV_WDT] = ev.wdt_overflow || ev.wdt_interval;
		ev_set[SFI_EV_KEY] = ev.wdt_key_violation;
		ev_set[SFI_EV_OSC] = ev.osc_fault;
		ev_set[SFI_EV_NMI] = ev.nmi_pin;
		ev_set[SFI_EV_ACCV] = ev.flash_violation;
		ev_clr = SFI_EV_RST_VALUE;
		if (wr_stb && acc.idx == SFI_IDX_IRQ_CLEAR)
			ev_clr = acc.wdata[SFI_EV_N-1:0];
	end

	sfi_sticky_bits #(
		.W(SFI_EV_N),
		.PRESENT(SFI_EV_MASK),
		.RST_VALUE(SFI_EV_RST_VALUE)
	) u_status (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.set_in(ev_set),
		.clr_in(ev_clr),
		.wr_in(1'b0),
		.wdata_in(SFI_EV_RST_VALUE),
		.q_out(irq_status)
	);

	// Read mux; high bytes and absent bits read zero
	always_comb
	begin
		if (acc.idx == SFI_IDX_EN_LOW)
			rd_mux = en_low;
		else if (acc.idx == SFI_IDX_EN_HIGH)
			rd_mux = SFI_HIGH_MASK;
		else if (acc.idx == SFI_IDX_FLAG_LOW)
			rd_mux = flag_low;
		else if (acc.idx == SFI_IDX_FLAG_HIGH)
			rd_mux = SFI_HIGH_MASK;
		else if (acc.idx == SFI_IDX_IRQ_STATUS)
			rd_mux = {{(SFI_REG_W-SFI_EV_N){1'b0}}, irq_status};
		else if (acc.idx == SFI_IDX_IRQ_ENABLE)
			rd_mux = {{(SFI_REG_W-SFI_EV_N){1'b0}}, irq_enable};
		else if (acc.idx == SFI_IDX_PORT2_FLAGS)
			rd_mux = port2_irq_flags;
		else
			rd_mux = SFI_RST_VALUE;
		next_readdata = readdata_out;
		if (take && read_in)
			next_readdata = {{(SFI_DATA_W-SFI_REG_W){1'b0}}, rd_mux};
	end

	// Request gating; registered so every output but waitrequest_out comes from a flop
	always_comb
	begin
		next_nmi_request = (flag_low[SFI_BIT_OSC] && osc_fault_irq_enable)
			|| (flag_low[SFI_BIT_NMI] && pin_nmi_irq_enable)
			|| (flash_violation_in && flash_violation_irq_enable);
		next_wdt_irq_request = flag_low[SFI_BIT_WDT] && watchdog_irq_enable
			&& wdt_interval_mode_in && gie_in;
		// Reset-mode expiry and key violation ignore every enable
		next_wdt_reset_request = (ev.wdt_overflow && !wdt_interval_mode_in)
			|| ev.wdt_key_violation;
		next_irq = |(irq_status & irq_enable);
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			readdata_out <= '0;
			nmi_request_out <= 1'b0;
			wdt_irq_request_out <= 1'b0;
			wdt_reset_request_out <= 1'b0;
			irq_out <= 1'b0;
		end
		else
		begin
			readdata_out <= next_readdata;
			nmi_request_out <= next_nmi_request;
			wdt_irq_request_out <= next_wdt_irq_request;
			wdt_reset_request_out <= next_wdt_reset_request;
			irq_out <= next_irq;
		end
	end

	assign waitrequest_out = wait_q;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_bus_take;
		(read_in || write_in) && waitrequest_out;
	endsequence
	sequence s_bus_answer;
		!waitrequest_out ##1 waitrequest_out;
	endsequence

	property p_bus_one_wait;
		s_bus_take |=> s_bus_answer;
	endproperty
	a_bus_one_wait: assert property (p_bus_one_wait)
		else $error("bus answer not after one wait cycle");

	property p_nonmask_reset;
		(wdt_overflow_in && !wdt_interval_mode_in) |=> wdt_reset_request_out;
	endproperty
	a_nonmask_reset: assert property (p_nonmask_reset)
		else $error("reset-mode expiry gave no reset request");

	property p_nmi_ignores_gie;
		(flag_low[SFI_BIT_NMI] && pin_nmi_irq_enable && !gie_in) |=> nmi_request_out;
	endproperty
	a_nmi_ignores_gie: assert property (p_nmi_ignores_gie)
		else $error("nmi request blocked by global enable");

	property p_nmi_gated;
		!(osc_fault_irq_enable || pin_nmi_irq_enable || flash_violation_irq_enable)
			|=> !nmi_request_out;
	endproperty
	a_nmi_gated: assert property (p_nmi_gated)
		else $error("nmi request with all enables off");

	property p_absent_zero;
		((en_low & ~SFI_EN_LOW_MASK) == 8'h00) && ((flag_low & ~SFI_FLAG_LOW_MASK) == 8'h00)
			&& (readdata_out[SFI_DATA_W-1:SFI_REG_W] == 24'h000000);
	endproperty
	a_absent_zero: assert property (p_absent_zero)
		else $error("absent bit reads nonzero");

	property p_wdt_ie_reset_mode;
		!wdt_interval_mode_in |=> !wdt_irq_request_out;
	endproperty
	a_wdt_ie_reset_mode: assert property (p_wdt_ie_reset_mode)
		else $error("watchdog interrupt in reset mode");

	property p_puc_enables;
		power_up_clear_in |=> (en_low == 8'h00);
	endproperty
	a_puc_enables: assert property (p_puc_enables)
		else $error("enables not cleared by power-up clear");

	property p_wdt_flag_set;
		((wdt_overflow_in && !wdt_interval_mode_in) || wdt_key_violation_in)
			|=> flag_low[SFI_BIT_WDT];
	endproperty
	a_wdt_flag_set: assert property (p_wdt_flag_set)
		else $error("watchdog flag not set");

	property p_wdt_flag_pin_clear;
		(rst_pin_reset_in && !wdt_overflow_in && !wdt_key_violation_in && !wdt_interval_in)
			|=> !flag_low[SFI_BIT_WDT];
	endproperty
	a_wdt_flag_pin_clear: assert property (p_wdt_flag_pin_clear)
		else $error("pin reset left watchdog flag set");

	property p_osc_set_wins;
		(osc_fault_in && wr_stb && acc.idx == SFI_IDX_FLAG_LOW) |=> flag_low[SFI_BIT_OSC];
	endproperty
	a_osc_set_wins: assert property (p_osc_set_wins)
		else $error("oscillator fault lost to write");

	property p_nmi_flag_set;
		nmi_pin_event_in |=> flag_low[SFI_BIT_NMI] ##1 (nmi_request_out || !$past(pin_nmi_irq_enable));
	endproperty
	a_nmi_flag_set: assert property (p_nmi_flag_set)
		else $error("nmi pin event not flagged");

	property p_port2_top;
		port2_edge_in[SFI_PORT2_N-1] |=> port2_irq_flags[SFI_PORT2_N-1];
	endproperty
	a_port2_top: assert property (p_port2_top)
		else $error("unbonded port flag missing");

	property p_irq_level;
		|(irq_status & irq_enable) |=> irq_out;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("enabled status gave no interrupt");
endmodule
`default_nettype wire

/* File: logic/sfi_pkg.sv */
/*
 * Shared constants and types of the system interrupt enable and flag block.
 * Assumes a 32-bit Avalon-MM register bus with word-index addressing.
 */
`default_nettype none
package sfi_pkg;
	localparam int SFI_ADDR_W = 4;
	localparam int SFI_DATA_W = 32;
	localparam int SFI_REG_W = 8;
	localparam int SFI_EV_N = 5;
	localparam int SFI_PORT2_N = 8;

	// Register indices; byte address is four times the index
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_EN_LOW = 4'h0;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_EN_HIGH = 4'h1;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_FLAG_LOW = 4'h2;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_FLAG_HIGH = 4'h3;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_IRQ_STATUS = 4'h4;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_IRQ_ENABLE = 4'h5;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_IRQ_CLEAR = 4'h6;
	localparam logic [SFI_ADDR_W-1:0] SFI_IDX_PORT2_FLAGS = 4'h7;

	// Bit positions in the low enable and flag bytes
	localparam int SFI_BIT_WDT = 0;
	localparam int SFI_BIT_OSC = 1;
	localparam int SFI_BIT_NMI = 4;
	localparam int SFI_BIT_ACCV = 5;

	// Physically present bits
	localparam logic [SFI_REG_W-1:0] SFI_EN_LOW_MASK = 8'h33;
	localparam logic [SFI_REG_W-1:0] SFI_FLAG_LOW_MASK = 8'h13;
	localparam logic [SFI_REG_W-1:0] SFI_HIGH_MASK = 8'h00;
	localparam logic [SFI_REG_W-1:0] SFI_FULL_MASK = 8'hFF;
	localparam logic [SFI_EV_N-1:0] SFI_EV_MASK = 5'h1F;

	// Flag bits that a power-up clear resets; the watchdog flag survives it
	localparam logic [SFI_REG_W-1:0] SFI_FLAG_PUC_CLR = 8'h12;
	localparam logic [SFI_REG_W-1:0] SFI_FLAG_WDT_ONLY = 8'h01;
	localparam logic [SFI_REG_W-1:0] SFI_RST_VALUE = 8'h00;
	localparam logic [SFI_EV_N-1:0] SFI_EV_RST_VALUE = 5'h00;

	// Event status bit positions
	localparam int SFI_EV_WDT = 0;
	localparam int SFI_EV_KEY = 1;
	localparam int SFI_EV_OSC = 2;
	localparam int SFI_EV_NMI = 3;
	localparam int SFI_EV_ACCV = 4;

	typedef enum logic [1:0] {
		SFI_BUS_IDLE = 2'b01,
		SFI_BUS_ACK = 2'b10
	} sfi_bus_state_e;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [SFI_ADDR_W-1:0] idx;
		logic [SFI_REG_W-1:0] wdata;
	} sfi_access_s;

	typedef struct packed {
		logic wdt_overflow;
		logic wdt_key_violation;
		logic wdt_interval;
		logic osc_fault;
		logic nmi_pin;
		logic flash_violation;
	} sfi_event_s;
endpackage
`default_nettype wire

/* File: logic/sfi_sticky_bits.sv */
/*
 * Row of sticky bits: hardware set, software write, clear strobes.
 * Assumes set and clear strobes are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sfi_sticky_bits
	import sfi_pkg::*;
#(
	parameter int W = 8,
	parameter logic [W-1:0] PRESENT = '1,
	parameter logic [W-1:0] RST_VALUE = '0
)
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] set_in,
	input wire logic [W-1:0] clr_in,
	input wire logic wr_in,
	input wire logic [W-1:0] wdata_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] next_q;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			if (PRESENT[i])
			begin : g_present
				// Set beats both the clear strobe and a software write of zero
				always_comb
				begin
					next_q[i] = set_in[i] | ((wr_in ? wdata_in[i] : q_out[i]) & ~clr_in[i]);
				end
				always_ff @(posedge mclk_in or negedge rst_n_in)
				begin
					if (!rst_n_in)
						q_out[i] <= RST_VALUE[i];
					else
						q_out[i] <= next_q[i];
				end
			end
			else
			begin : g_absent
				// Absent bit: no storage, reads as zero
				assign next_q[i] = 1'b0;
				assign q_out[i] = 1'b0;
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: logic/sfi_avalon_slave.sv */
/*
 * Avalon-MM slave handshake: one wait cycle, then a one-cycle access strobe.
 * Assumes the master holds its request until waitrequest is seen low.
 */
`timescale 1ns/1ps
`default_nettype none
module sfi_avalon_slave
	import sfi_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [SFI_ADDR_W-1:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [SFI_DATA_W-1:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic waitrequest_out,
	output logic take_out,
	output sfi_access_s access_out
);
	sfi_bus_state_e state;
	sfi_bus_state_e next_state;

	always_comb
	begin
		next_state = state;
		case (state)
			SFI_BUS_IDLE:
				if (read_in || write_in)
					next_state = SFI_BUS_ACK;
			SFI_BUS_ACK:
				next_state = SFI_BUS_IDLE;
			default:
				next_state = SFI_BUS_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state <= SFI_BUS_IDLE;
		else
			state <= next_state;
	end

	// Waitrequest is low exactly in the ACK cycle
	assign waitrequest_out = (state != SFI_BUS_ACK);
	assign take_out = (state == SFI_BUS_IDLE) && (read_in || write_in);
	// Data sits in the low byte lane; other lanes are ignored
	assign access_out.rd = read_in;
	assign access_out.wr = write_in && byteenable_in[0];
	assign access_out.idx = address_in;
	assign access_out.wdata = writedata_in[SFI_REG_W-1:0];
endmodule
`default_nettype wire

/* File: bench/sfi_event_model.sv */
/*
 * Far-side event sources: watchdog, clock module, pin logic, flash, port 2.
 * Assumes the bench raises fire_in bits on clock edges, by NBA.
 */
`timescale 1ns/1ps
`default_nettype none
module sfi_event_model
	import sfi_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire sfi_event_s fire_in,
	input wire logic [SFI_PORT2_N-1:0] p2_fire_in,
	output var sfi_event_s ev_out,
	output logic [SFI_PORT2_N-1:0] p2_out
);
	// Registered, so events reach the block as clean synchronous pulses
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ev_out <= '0;
			p2_out <= '0;
		end
		else
		begin
			ev_out <= fire_in;
			p2_out <= p2_fire_in;
		end
	end
endmodule
`default_nettype wire

/* File: bench/sfr_interrupt_enable_flags_tb.sv */
/*
 * Self-checking bench of the system interrupt enable and flag block.
 * Assumes the block answers every bus request; only the watchdog ends a hang.
 */
`timescale 1ns/1ps
`default_nettype none
module sfr_interrupt_enable_flags_tb
	import sfi_pkg::*;
;
	logic clk, rst_n, power_up_clear, rd, wr, imode, rpin, gie;
	logic [3:0] adr;
	logic [3:0] be;
	logic [31:0] wd;
	logic [7:0] q, p2f;
	sfi_event_s fire, ev;
	wire logic [31:0] rdata;
	wire logic [7:0] p2;
	wire logic wt, nmi_o, wirq_o, wrst_o, irq_o;
	int mismatches = 0;
	int check_count = 0;
	int rst_pulses = 0;
	int n_rst;
	logic [3:0] t_idx [9] = '{4'h4, 4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8};
	logic [7:0] t_wd [9] = '{8'hFF, 8'hFF, 8'hAA, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0] t_ex [9] = '{8'h00, 8'h33, 8'h22, 8'h00, 8'h13, 8'h00, 8'h1F, 8'hFF, 8'h00};
	// Pin event, oscillator fault, flash level: held as levels
	logic [5:0] s_ev [3] = '{6'h02, 6'h04, 6'h01};
	logic [7:0] s_fl [3] = '{8'h10, 8'h02, 8'h00};
	logic [7:0] s_en [3] = '{8'h10, 8'h02, 8'h20};

	sfi_event_model i_model (.mclk_in(clk), .rst_n_in(rst_n), .fire_in(fire),
		.p2_fire_in(p2f), .ev_out(ev), .p2_out(p2));
	sfi_system_irq i_dut (.mclk_in(clk), .rst_n_in(rst_n), .power_up_clear_in(power_up_clear),
		.address_in(adr), .read_in(rd), .write_in(wr), .writedata_in(wd),
		.byteenable_in(be), .readdata_out(rdata), .waitrequest_out(wt),
		.wdt_overflow_in(ev.wdt_overflow), .wdt_key_violation_in(ev.wdt_key_violation),
		.wdt_interval_in(ev.wdt_interval), .wdt_interval_mode_in(imode),
		.osc_fault_in(ev.osc_fault), .nmi_pin_event_in(ev.nmi_pin),
		.rst_pin_reset_in(rpin), .flash_violation_in(ev.flash_violation), .gie_in(gie),
		.port2_edge_in(p2), .nmi_request_out(nmi_o), .wdt_irq_request_out(wirq_o),
		.wdt_reset_request_out(wrst_o), .irq_out(irq_o));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Reset requests are one-cycle pulses; counting them also catches a stretched one
	always @(posedge clk)
		if (wrst_o === 1'b1)
			rst_pulses <= rst_pulses + 1;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask

	// Holds the request until waitrequest is sampled low; the watchdog ends a hang
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h000000, d};
		@(posedge clk);
		while (wt !== 1'b0)
			@(posedge clk);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulse(input logic [5:0] v);
		fire <= sfi_event_s'(v);
		@(posedge clk);
		fire <= '0;
		wait_n(4);
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		wait_n(8);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	initial
	begin
		#100000;
		mismatches++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	end

	initial
	begin
		{rst_n, power_up_clear, rd, wr, imode, rpin, gie} = 7'h00;
		adr = 4'h0;
		be = 4'hF;
		wd = 32'h00000000;
		p2f = 8'h00;
		fire = '0;
		@(posedge clk);
		do_reset();
		for (int i = 0; i < 9; i++)
		begin
			bus(1'b1, t_idx[i], t_wd[i]);
			rchk(t_idx[i], t_ex[i]);
		end
		$display("register table done");
		do_reset();
		rchk(4'h0, 8'h00);
		rchk(4'h2, 8'h00);
		rchk(4'h7, 8'h00);
		$display("power-on reset done");
		bus(1'b1, 4'h0, 8'h33);
		bus(1'b1, 4'h2, 8'h13);
		bus(1'b1, 4'h7, 8'hFF);
		power_up_clear <= 1'b1;
		@(posedge clk);
		power_up_clear <= 1'b0;
		@(posedge clk);
		rchk(4'h0, 8'h00);
		rchk(4'h2, 8'h01);
		rchk(4'h7, 8'h00);
		bus(1'b1, 4'h2, 8'h00);
		$display("power-up clear done");
		n_rst = rst_pulses;
		pulse(6'h20);
		chk(8'(rst_pulses - n_rst), 8'h01);
		rchk(4'h2, 8'h01);
		bus(1'b1, 4'h2, 8'h00);
		n_rst = rst_pulses;
		pulse(6'h10);
		chk(8'(rst_pulses - n_rst), 8'h01);
		rchk(4'h2, 8'h01);
		rpin <= 1'b1;
		@(posedge clk);
		rpin <= 1'b0;
		@(posedge clk);
		rchk(4'h2, 8'h00);
		$display("watchdog reset class done");
		imode <= 1'b1;
		gie <= 1'b1;
		pulse(6'h08);
		chk({7'h00, wirq_o}, 8'h00);
		bus(1'b1, 4'h0, 8'h01);
		wait_n(3);
		chk({7'h00, wirq_o}, 8'h01);
		// Watchdog interval request is maskable: the global enable blocks it
		gie <= 1'b0;
		wait_n(3);
		chk({7'h00, wirq_o}, 8'h00);
		gie <= 1'b1;
		imode <= 1'b0;
		wait_n(3);
		chk({7'h00, wirq_o}, 8'h00);
		bus(1'b1, 4'h0, 8'h00);
		bus(1'b1, 4'h2, 8'h00);
		$display("watchdog interval done");
		for (int i = 0; i < 3; i++)
		begin
			gie <= 1'b1;
			fire <= sfi_event_s'(s_ev[i]);
			wait_n(4);
			rchk(4'h2, s_fl[i]);
			chk({7'h00, nmi_o}, 8'h00);
			gie <= 1'b0;
			bus(1'b1, 4'h0, s_en[i]);
			wait_n(4);
			chk({7'h00, nmi_o}, 8'h01);
			fire <= '0;
			bus(1'b1, 4'h0, 8'h00);
			bus(1'b1, 4'h2, 8'h00);
		end
		$display("nonmaskable sources done");
		fire <= sfi_event_s'(6'h04);
		wait_n(3);
		bus(1'b1, 4'h2, 8'h00);
		rchk(4'h2, 8'h02);
		fire <= '0;
		bus(1'b1, 4'h2, 8'h00);
		rchk(4'h2, 8'h00);
		$display("set priority done");
		// Every source has fired by now and the status row is sticky
		rchk(4'h4, 8'h1F);
		bus(1'b1, 4'h6, 8'h1F);
		bus(1'b1, 4'h5, 8'h08);
		pulse(6'h02);
		chk({7'h00, irq_o}, 8'h01);
		bus(1'b1, 4'h5, 8'h00);
		// Interrupt output is registered one edge behind the write
		wait_n(1);
		chk({7'h00, irq_o}, 8'h00);
		rchk(4'h4, 8'h08);
		bus(1'b1, 4'h5, 8'h08);
		wait_n(1);
		chk({7'h00, irq_o}, 8'h01);
		bus(1'b1, 4'h6, 8'h08);
		wait_n(1);
		chk({7'h00, irq_o}, 8'h00);
		rchk(4'h4, 8'h00);
		bus(1'b1, 4'h2, 8'h00);
		$display("event interrupt done");
		p2f <= 8'h80;
		@(posedge clk);
		p2f <= 8'h00;
		wait_n(4);
		rchk(4'h7, 8'h80);
		rchk(4'h2, 8'h00);
		$display("port two flags done");
		end_sim();
	end
endmodule
`default_nettype wire
